// >>> logic/mccd_pkg.sv
// package for the machine cycle clock divider: addresses, fields, reset values
package mccd_pkg;

  localparam logic [7:0] MCCD_ADDR_POWER_MANAGEMENT = 8'hc4;
  localparam logic [7:0] MCCD_ADDR_CORE_STATUS      = 8'hc5;

  // power_management field positions
  localparam int MCCD_PM_DIV_HI_BIT   = 7;
  localparam int MCCD_PM_DIV_LO_BIT   = 6;
  localparam int MCCD_PM_SBACK_BIT    = 5;
  localparam int MCCD_PM_ALE_OFF_BIT  = 2;
  localparam int MCCD_PM_XRAM_EN_BIT  = 0;

  // core_status field positions
  localparam int MCCD_ST_HI_ACT_BIT   = 7;
  localparam int MCCD_ST_LO_ACT_BIT   = 6;
  localparam int MCCD_ST_OSC_RDY_BIT  = 4;
  localparam int MCCD_ST_P1_TX_BIT    = 3;
  localparam int MCCD_ST_P1_RX_BIT    = 2;
  localparam int MCCD_ST_P0_TX_BIT    = 1;
  localparam int MCCD_ST_P0_RX_BIT    = 0;

  typedef enum logic [1:0] {
    MCCD_DIV_RSVD = 2'b00,
    MCCD_DIV_4    = 2'b01,
    MCCD_DIV_64   = 2'b10,
    MCCD_DIV_1024 = 2'b11
  } mccd_div_e;

  localparam logic [10:0] MCCD_CNT_DIV_4    = 11'h004;
  localparam logic [10:0] MCCD_CNT_DIV_64   = 11'h040;
  localparam logic [10:0] MCCD_CNT_DIV_1024 = 11'h400;

  localparam logic      MCCD_RST_SBACK    = 1'b0;
  localparam logic      MCCD_RST_ALE_OFF  = 1'b0;
  localparam logic      MCCD_RST_XRAM_EN  = 1'b0;
  localparam logic      MCCD_RST_OSC_RDY  = 1'b1;

  // serial port event group
  typedef struct packed {
    logic p1_tx_start;
    logic p1_tx_done;
    logic p1_rx_start;
    logic p1_rx_done;
    logic p0_tx_start;
    logic p0_tx_done;
    logic p0_rx_start;
    logic p0_rx_done;
  } mccd_serial_s;

  // cpu special function register access group
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mccd_sfr_s;

endpackage : mccd_pkg

// >>> logic/mccd_clock_divider.sv
// machine cycle clock divider with switchback, power bits and core status
// Operation
// - divide code 01/10/11 gives 4/64/1024 clocks
// - switchback enable forces divide-by-4 on events
// - external interrupt switchback at vector jump, when recognized
// - receive switchback at instruction after start edge
// - latch suppress holds strobe off for on-chip accesses
// - external accesses always drive the latch strobe
// - onchip xram enable bit gates internal data RAM
// - high priority active set in service, cleared return
// - low priority active set in service, cleared return
// - osc ready cleared on wake, set when ready
// - port1 tx active until port1 tx done
// - port1 rx active until port1 rx done
// - port0 tx active until port0 tx done
// - port0 rx active until port0 rx done
// - divide writes ignored while switchback and activity
// - power down stops machine cycles and drops clock run
`timescale 1ns/1ns
`default_nettype none

module mccd_clock_divider (
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RST_I,
  input  wire mccd_pkg::mccd_sfr_s   SFR_I,
  output logic [7:0]                 SFR_RDATA_O,
  input  wire mccd_pkg::mccd_serial_s SERIAL_I,
  input  wire logic                  IRQ_VECTOR_I,
  input  wire logic                  IRQ_HIGH_PRIO_I,
  input  wire logic                  IRQ_EXTERNAL_I,
  input  wire logic                  IRQ_RETURN_I,
  input  wire logic                  INSTR_START_I,
  input  wire logic                  POWER_DOWN_REQUEST_I,
  input  wire logic                  WAKE_I,
  input  wire logic                  OSC_STABLE_I,
  input  wire logic                  EXT_ACCESS_I,
  input  wire logic                  LATCH_STROBE_REQ_I,
  output logic                       LATCH_STROBE_O,
  output logic                       XRAM_ENABLE_O,
  output logic                       MACHINE_CYCLE_O,
  output logic                       CLOCK_RUN_O,
  output logic [1:0]                 DIV_SEL_O
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] div_count(input logic [1:0] code);
    unique case (code)
      mccd_pkg::MCCD_DIV_64:   div_count = mccd_pkg::MCCD_CNT_DIV_64;
      mccd_pkg::MCCD_DIV_1024: div_count = mccd_pkg::MCCD_CNT_DIV_1024;
      default:                 div_count = mccd_pkg::MCCD_CNT_DIV_4;
    endcase
  endfunction : div_count

  logic [1:0]  div_r,      div_nxt;
  logic        sback_r,    sback_nxt;
  logic        ale_off_r,  ale_off_nxt;
  logic        xram_r,     xram_nxt;
  logic        hi_act_r,   hi_act_nxt;
  logic        lo_act_r,   lo_act_nxt;
  logic        osc_rdy_r,  osc_rdy_nxt;
  logic        pwr_dn_r,   pwr_dn_nxt;
  logic        rx_pend_r,  rx_pend_nxt;
  logic [3:0]  act_r,      act_nxt;
  logic [10:0] cnt_r,      cnt_nxt;
  logic        mc_r,       mc_nxt;
  logic [7:0]  rdata_r,    rdata_nxt;
  logic        any_act;
  logic        wr_pm;
  logic        sback_irq;
  logic        sback_rx;

  assign wr_pm   = SFR_I.wr && (SFR_I.addr == mccd_pkg::MCCD_ADDR_POWER_MANAGEMENT);
  assign any_act = |act_r;
  assign sback_irq = sback_r && IRQ_VECTOR_I && IRQ_EXTERNAL_I;
  assign sback_rx  = sback_r && rx_pend_r && INSTR_START_I;

  ////////////////////////////////////////////////////////////////////////////
  // power management register and switchback
  always_comb begin
    div_nxt     = div_r;
    sback_nxt   = sback_r;
    ale_off_nxt = ale_off_r;
    xram_nxt    = xram_r;
    rx_pend_nxt = rx_pend_r;
    if (wr_pm) begin
      sback_nxt   = SFR_I.wdata[mccd_pkg::MCCD_PM_SBACK_BIT];
      ale_off_nxt = SFR_I.wdata[mccd_pkg::MCCD_PM_ALE_OFF_BIT];
      xram_nxt    = SFR_I.wdata[mccd_pkg::MCCD_PM_XRAM_EN_BIT];
      if (!(sback_r && any_act)) begin
        div_nxt = {SFR_I.wdata[mccd_pkg::MCCD_PM_DIV_HI_BIT],
                   SFR_I.wdata[mccd_pkg::MCCD_PM_DIV_LO_BIT]};
      end
    end
    if (SERIAL_I.p0_rx_start || SERIAL_I.p1_rx_start) begin
      rx_pend_nxt = 1'b1;
    end else if (INSTR_START_I) begin
      rx_pend_nxt = 1'b0;
    end
    if (sback_irq || sback_rx) begin
      div_nxt = mccd_pkg::MCCD_DIV_4;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      div_r     <= mccd_pkg::MCCD_DIV_4;
      sback_r   <= mccd_pkg::MCCD_RST_SBACK;
      ale_off_r <= mccd_pkg::MCCD_RST_ALE_OFF;
      xram_r    <= mccd_pkg::MCCD_RST_XRAM_EN;
      rx_pend_r <= 1'b0;
    end else begin
      div_r     <= div_nxt;
      sback_r   <= sback_nxt;
      ale_off_r <= ale_off_nxt;
      xram_r    <= xram_nxt;
      rx_pend_r <= rx_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: set wins over clear, except wake wins over power down request and over osc stable
  always_comb begin
    hi_act_nxt  = hi_act_r;
    lo_act_nxt  = lo_act_r;
    osc_rdy_nxt = osc_rdy_r;
    pwr_dn_nxt  = pwr_dn_r;
    act_nxt     = act_r;
    if (IRQ_RETURN_I) begin
      if (hi_act_r) hi_act_nxt = 1'b0;
      else          lo_act_nxt = 1'b0;
    end
    if (IRQ_VECTOR_I) begin
      if (IRQ_HIGH_PRIO_I) hi_act_nxt = 1'b1;
      else                 lo_act_nxt = 1'b1;
    end
    if (POWER_DOWN_REQUEST_I) pwr_dn_nxt = 1'b1;
    if (pwr_dn_r && WAKE_I) begin
      pwr_dn_nxt  = 1'b0;
      osc_rdy_nxt = 1'b0;
    end else if (!pwr_dn_r && OSC_STABLE_I) begin
      osc_rdy_nxt = 1'b1;
    end
    if (SERIAL_I.p1_tx_done)  act_nxt[3] = 1'b0;
    if (SERIAL_I.p1_tx_start) act_nxt[3] = 1'b1;
    if (SERIAL_I.p1_rx_done)  act_nxt[2] = 1'b0;
    if (SERIAL_I.p1_rx_start) act_nxt[2] = 1'b1;
    if (SERIAL_I.p0_tx_done)  act_nxt[1] = 1'b0;
    if (SERIAL_I.p0_tx_start) act_nxt[1] = 1'b1;
    if (SERIAL_I.p0_rx_done)  act_nxt[0] = 1'b0;
    if (SERIAL_I.p0_rx_start) act_nxt[0] = 1'b1;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      hi_act_r  <= 1'b0;
      lo_act_r  <= 1'b0;
      osc_rdy_r <= mccd_pkg::MCCD_RST_OSC_RDY;
      pwr_dn_r  <= 1'b0;
      act_r     <= 4'h0;
    end else begin
      hi_act_r  <= hi_act_nxt;
      lo_act_r  <= lo_act_nxt;
      osc_rdy_r <= osc_rdy_nxt;
      pwr_dn_r  <= pwr_dn_nxt;
      act_r     <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle divider and read data
  always_comb begin
    cnt_nxt = cnt_r;
    mc_nxt  = 1'b0;
    if (!pwr_dn_r) begin
      if (cnt_r >= div_count(div_r) - 11'h001) begin
        cnt_nxt = 11'h000;
        mc_nxt  = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 11'h001;
      end
    end
    rdata_nxt = 8'h00;
    if (SFR_I.rd && SFR_I.addr == mccd_pkg::MCCD_ADDR_POWER_MANAGEMENT) begin
      rdata_nxt[mccd_pkg::MCCD_PM_DIV_HI_BIT]  = div_r[1];
      rdata_nxt[mccd_pkg::MCCD_PM_DIV_LO_BIT]  = div_r[0];
      rdata_nxt[mccd_pkg::MCCD_PM_SBACK_BIT]   = sback_r;
      rdata_nxt[mccd_pkg::MCCD_PM_ALE_OFF_BIT] = ale_off_r;
      rdata_nxt[mccd_pkg::MCCD_PM_XRAM_EN_BIT] = xram_r;
    end else if (SFR_I.rd && SFR_I.addr == mccd_pkg::MCCD_ADDR_CORE_STATUS) begin
      rdata_nxt[mccd_pkg::MCCD_ST_HI_ACT_BIT]  = hi_act_r;
      rdata_nxt[mccd_pkg::MCCD_ST_LO_ACT_BIT]  = lo_act_r;
      rdata_nxt[mccd_pkg::MCCD_ST_OSC_RDY_BIT] = osc_rdy_r;
      rdata_nxt[mccd_pkg::MCCD_ST_P1_TX_BIT]   = act_r[3];
      rdata_nxt[mccd_pkg::MCCD_ST_P1_RX_BIT]   = act_r[2];
      rdata_nxt[mccd_pkg::MCCD_ST_P0_TX_BIT]   = act_r[1];
      rdata_nxt[mccd_pkg::MCCD_ST_P0_RX_BIT]   = act_r[0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cnt_r   <= 11'h000;
      mc_r    <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      cnt_r   <= cnt_nxt;
      mc_r    <= mc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA_O     = rdata_r;
  assign MACHINE_CYCLE_O = mc_r;
  assign CLOCK_RUN_O     = !pwr_dn_r;
  assign DIV_SEL_O       = div_r;
  assign XRAM_ENABLE_O   = xram_r;
  assign LATCH_STROBE_O  = LATCH_STROBE_REQ_I && (EXT_ACCESS_I || !ale_off_r);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_div_period;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (mc_r && !pwr_dn_r && div_r == mccd_pkg::MCCD_DIV_4 && !$changed(div_r))
        ##1 (div_r == mccd_pkg::MCCD_DIV_4 && !pwr_dn_r) [*3] |-> ##1 mc_r;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divide by 4 period wrong");

  property p_sback_irq;
    @(posedge REF_CLK_I) disable iff (RST_I)
      sback_r && IRQ_VECTOR_I && IRQ_EXTERNAL_I |=> div_r == mccd_pkg::MCCD_DIV_4;
  endproperty
  a_sback_irq: assert property (p_sback_irq) else $error("no switchback on interrupt");

  property p_sback_rx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      sback_r && rx_pend_r && INSTR_START_I |=> div_r == mccd_pkg::MCCD_DIV_4;
  endproperty
  a_sback_rx: assert property (p_sback_rx) else $error("no switchback on receive");

  property p_div_locked;
    @(posedge REF_CLK_I) disable iff (RST_I)
      sback_r && any_act && !IRQ_VECTOR_I |=> $stable(div_r) || div_r == mccd_pkg::MCCD_DIV_4;
  endproperty
  a_div_locked: assert property (p_div_locked) else $error("divide changed while locked");

  property p_strobe;
    @(posedge REF_CLK_I) disable iff (RST_I)
      LATCH_STROBE_REQ_I && (EXT_ACCESS_I || !ale_off_r) |-> LATCH_STROBE_O;
  endproperty
  a_strobe: assert property (p_strobe) else $error("latch strobe missing");

  property p_strobe_off;
    @(posedge REF_CLK_I) disable iff (RST_I)
      ale_off_r && !EXT_ACCESS_I |-> !LATCH_STROBE_O;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("latch strobe not suppressed");

  property p_osc_wake;
    @(posedge REF_CLK_I) disable iff (RST_I)
      pwr_dn_r && WAKE_I |=> !osc_rdy_r && !pwr_dn_r;
  endproperty
  a_osc_wake: assert property (p_osc_wake) else $error("osc ready not cleared on wake");

  property p_dn_freeze;
    @(posedge REF_CLK_I) disable iff (RST_I)
      pwr_dn_r ##1 pwr_dn_r |-> !mc_r && !CLOCK_RUN_O;
  endproperty
  a_dn_freeze: assert property (p_dn_freeze) else $error("cycles run in power down");

  property p_p0_rx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      SERIAL_I.p0_rx_done && !SERIAL_I.p0_rx_start |=> !act_r[0];
  endproperty
  a_p0_rx: assert property (p_p0_rx) else $error("rx activity not cleared");

  property p_hi_act;
    @(posedge REF_CLK_I) disable iff (RST_I)
      IRQ_VECTOR_I && IRQ_HIGH_PRIO_I |=> hi_act_r;
  endproperty
  a_hi_act: assert property (p_hi_act) else $error("high priority flag not set");

  property p_lo_act;
    @(posedge REF_CLK_I) disable iff (RST_I)
      IRQ_VECTOR_I && !IRQ_HIGH_PRIO_I |=> lo_act_r;
  endproperty
  a_lo_act: assert property (p_lo_act) else $error("low priority flag not set");

  property p_p1_tx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      SERIAL_I.p1_tx_done && !SERIAL_I.p1_tx_start |=> !act_r[3];
  endproperty
  a_p1_tx: assert property (p_p1_tx) else $error("tx activity not cleared");

  property p_xram;
    @(posedge REF_CLK_I) disable iff (RST_I)
      wr_pm |=> XRAM_ENABLE_O == $past(SFR_I.wdata[mccd_pkg::MCCD_PM_XRAM_EN_BIT]);
  endproperty
  a_xram: assert property (p_xram) else $error("onchip ram enable not written");

  property p_div_reset;
    @(posedge REF_CLK_I)
      RST_I |=> div_r == mccd_pkg::MCCD_DIV_4;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divide field not reset");

  c_sback_irq: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    sback_irq && div_r != mccd_pkg::MCCD_DIV_4);
  c_locked:  cover property (@(posedge REF_CLK_I) disable iff (RST_I) wr_pm && sback_r && any_act);
  c_wake:    cover property (@(posedge REF_CLK_I) disable iff (RST_I) pwr_dn_r && WAKE_I);

endmodule : mccd_clock_divider
`default_nettype wire

// >>> bench/mccd_clock_divider_tb.sv
// self-checking bench for the machine cycle clock divider
`timescale 1ns/1ns
`default_nettype none

module mccd_clock_divider_tb;
  logic                   clk;
  logic                   rst;
  mccd_pkg::mccd_sfr_s    sfr;
  mccd_pkg::mccd_serial_s ser;
  logic                   vec, hi, ext, ret, ins, pdn, wake, osc, xacc, lreq;
  logic [7:0]             rdata;
  logic [7:0]             rd;
  logic                   lstb, xram, mc, run;
  logic [1:0]             div;
  int                     failures;
  int                     n_checks;
  int                     n;

  mccd_clock_divider uut (
    .REF_CLK_I            (clk),
    .RST_I                (rst),
    .SFR_I                (sfr),
    .SFR_RDATA_O          (rdata),
    .SERIAL_I             (ser),
    .IRQ_VECTOR_I         (vec),
    .IRQ_HIGH_PRIO_I      (hi),
    .IRQ_EXTERNAL_I       (ext),
    .IRQ_RETURN_I         (ret),
    .INSTR_START_I        (ins),
    .POWER_DOWN_REQUEST_I (pdn),
    .WAKE_I               (wake),
    .OSC_STABLE_I         (osc),
    .EXT_ACCESS_I         (xacc),
    .LATCH_STROBE_REQ_I   (lreq),
    .LATCH_STROBE_O       (lstb),
    .XRAM_ENABLE_O        (xram),
    .MACHINE_CYCLE_O      (mc),
    .CLOCK_RUN_O          (run),
    .DIV_SEL_O            (div)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    sfr = '0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    sfr = '0;
    rd = rdata;
  endtask : rdr

  // one-cycle serial event pulse
  task automatic sp(input int i);
    @(negedge clk);
    ser[i] = 1'b1;
    @(negedge clk);
    ser = '0;
  endtask : sp

  // pulse of {return, instr start, power down, wake}
  task automatic cp(input logic [3:0] m);
    @(negedge clk);
    {ret, ins, pdn, wake} = m;
    @(negedge clk);
    {ret, ins, pdn, wake} = 4'h0;
  endtask : cp

  task automatic irq(input logic e, input logic h);
    @(negedge clk);
    vec = 1'b1;
    ext = e;
    hi = h;
    @(negedge clk);
    {vec, ext, hi} = 3'b000;
  endtask : irq

  // third gap is a full period whatever the counter phase was
  task automatic period(output int cnt);
    for (int k = 0; k < 3; k++) begin
      cnt = 0;
      do begin
        @(negedge clk);
        cnt++;
      end while (mc !== 1'b1 && cnt < 3000);
    end
  endtask : period

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #400000;
    failures++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    sfr = '0;
    ser = '0;
    {vec, hi, ext, ret, ins, pdn, wake, xacc, lreq} = 9'h000;
    osc = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(11'(div), 11'h001);
    rdr(8'hc4);
    check(11'(rd), 11'h040);
    rdr(8'hc5);
    check(11'(rd), 11'h010);
    rdr(8'hc6);
    check(11'(rd), 11'h000);
    period(n);
    check(11'(n), mccd_pkg::MCCD_CNT_DIV_4);
    wr(8'hc4, 8'h00);
    check(11'(div), 11'h000);
    period(n);
    check(11'(n), mccd_pkg::MCCD_CNT_DIV_4);
    wr(8'hc4, 8'h80);
    check(11'(div), 11'h002);
    period(n);
    check(11'(n), mccd_pkg::MCCD_CNT_DIV_64);
    wr(8'hc4, 8'h40);
    wr(8'hc4, 8'hc0);
    period(n);
    check(11'(n), mccd_pkg::MCCD_CNT_DIV_1024);
    wr(8'hc4, 8'h41);
    check(11'(xram), 11'h001);
    lreq = 1'b1;
    wr(8'hc4, 8'h44);
    check(11'(xram), 11'h000);
    check(11'(lstb), 11'h000);
    xacc = 1'b1;
    @(negedge clk);
    check(11'(lstb), 11'h001);
    xacc = 1'b0;
    wr(8'hc4, 8'h40);
    check(11'(lstb), 11'h001);
    for (int b = 0; b < 4; b++) begin
      sp(2 * b + 1);
      rdr(8'hc5);
      check(11'(rd), 11'(8'h10 | (8'h01 << b)));
      sp(2 * b);
      rdr(8'hc5);
      check(11'(rd), 11'h010);
    end
    sp(7);
    wr(8'hc4, 8'h80);
    check(11'(div), 11'h002);
    sp(6);
    wr(8'hc4, 8'h60);
    sp(3);
    wr(8'hc4, 8'ha0);
    check(11'(div), 11'h001);
    rdr(8'hc4);
    check(11'(rd), 11'h060);
    sp(2);
    wr(8'hc4, 8'ha0);
    check(11'(div), 11'h002);
    irq(1'b1, 1'b1);
    check(11'(div), 11'h001);
    rdr(8'hc5);
    check(11'(rd), 11'h090);
    cp(4'b1000);
    rdr(8'hc5);
    check(11'(rd), 11'h010);
    wr(8'hc4, 8'ha0);
    irq(1'b0, 1'b0);
    check(11'(div), 11'h002);
    rdr(8'hc5);
    check(11'(rd), 11'h050);
    cp(4'b1000);
    rdr(8'hc5);
    check(11'(rd), 11'h010);
    wr(8'hc4, 8'h80);
    irq(1'b1, 1'b0);
    check(11'(div), 11'h002);
    cp(4'b1000);
    cp(4'b0100);
    wr(8'hc4, 8'ha0);
    cp(4'b0100);
    check(11'(div), 11'h002);
    sp(1);
    check(11'(div), 11'h002);
    cp(4'b0100);
    check(11'(div), 11'h001);
    sp(0);
    cp(4'b0010);
    check(11'(run), 11'h000);
    n = 0;
    repeat (12) begin
      @(negedge clk);
      if (mc === 1'b1) n++;
    end
    check(11'(n), 11'h000);
    osc = 1'b0;
    cp(4'b0001);
    check(11'(run), 11'h001);
    rdr(8'hc5);
    check(11'(rd), 11'h000);
    osc = 1'b1;
    repeat (2) @(negedge clk);
    rdr(8'hc5);
    check(11'(rd), 11'h010);
    stop_test();
  end
endmodule : mccd_clock_divider_tb

`default_nettype wire
